// File: hdl/rx_link_status_map.svh
`ifndef RX_LINK_STATUS_MAP_SVH
`define RX_LINK_STATUS_MAP_SVH

// register indices; byte address is four times the index
`define IDX_LINK_ID    8'he3
`define IDX_STATE      8'he4
`define IDX_FRAME_SYNC 8'he5
`define IDX_CELL_SYNC  8'he6
`define IDX_LOAD_SEL   8'hf0
`define IDX_EV_STAT    8'hf1
`define IDX_EV_MASK    8'hf2

// reset values
`define LINK_ID_RST    16'h0020
`define STATE_RST      16'h0000

// link select field width
`define SEL_W          4

// delineation state codes
`define CD_HUNT        2'h0
`define CD_UNUSED      2'h3

// event bits
`define EV_W           3
`define EV_LOAD        0
`define EV_FRAME_LOST  1
`define EV_CELL_LOST   2

`endif

// File: hdl/rx_link_status_pkg.sv
`default_nettype none

package rx_link_status_pkg;

  // per-link status from the receive machines
  typedef struct packed {
    logic       frameLoss;
    logic       delinLoss;
    logic       refLink;
    logic [4:0] linkId;
    logic [1:0] frameLen;
    logic [1:0] frameState;
    logic [1:0] cellState;
  } link_status_t;

  // identity snapshot layout, msb first
  typedef struct packed {
    logic [7:0] zero;
    logic       frameLoss;
    logic       delinLoss;
    logic       refLink;
    logic [4:0] linkId;
  } id_reg_t;

  // state snapshot layout, msb first
  typedef struct packed {
    logic [9:0] zero;
    logic [1:0] frameLen;
    logic [1:0] frameState;
    logic [1:0] cellState;
  } state_reg_t;

endpackage

`default_nettype wire

// File: hdl/rx_link_status_readback.sv
// What this block does
// R1: snapshots refresh only on completed load write
// R2: snapshot link chosen by four-bit select
// R3: unused upper snapshot bits read zero
// R4: identity bit 7 shows frame loss
// R5: identity bit 6 shows delineation loss
// R6: identity bit 5 flags reference link
// R7: identity bits 4:0 hold link ID
// R8: identity resets 0x0020, others reset zero
// R9: state bits 5:4 show frame length
// R10: state bits 3:2 show frame state code
// R11: state bits 1:0 delineation code, never 11
// R12: frame sync register, one bit per link
// R13: frame sync bits live, never latched
// R14: cell sync register, one live bit per link
// R15: reads harmless, writes to status ignored
//
// Local design decision: the APB slave port.
`include "rx_link_status_map.svh"
`default_nettype none

module rx_link_status_readback #(
  parameter int NLINKS  = 16,
  parameter int PADDR_W = 12
)(
  input  wire logic                      clk,
  input  wire logic                      rst,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [PADDR_W-1:0]        paddr,
  input  wire logic [31:0]               pwdata,
  input  wire logic [3:0]                pstrb,
  input  wire rx_link_status_pkg::link_status_t [NLINKS-1:0] linkStat,
  input  wire logic [NLINKS-1:0]         frameSynced,
  input  wire logic [NLINKS-1:0]         cellSynced,
  output logic                           pready,
  output logic [31:0]                    prdata,
  output logic                           pslverr,
  output logic                           irq
);

  // address match against a word index
  function automatic logic regHit
  (
    input logic [PADDR_W-1:0] a,
    input logic [7:0]         idx
  );
    regHit = (a == PADDR_W'({idx, 2'b00}));
  endfunction

  rx_link_status_pkg::id_reg_t    linkIdSnap_ff;
  rx_link_status_pkg::state_reg_t stateSnap_ff;
  rx_link_status_pkg::id_reg_t    nxt_linkIdSnap;
  rx_link_status_pkg::state_reg_t nxt_stateSnap;
  rx_link_status_pkg::link_status_t cap;

  logic [`SEL_W-1:0] linkSel_ff;
  logic [`SEL_W-1:0] selNew;
  logic [`EV_W-1:0]  evStat_ff;
  logic [`EV_W-1:0]  evMask_ff;
  logic [`EV_W-1:0]  nxt_evStat;
  logic [`EV_W-1:0]  evSet;
  logic [`EV_W-1:0]  evClr;
  logic [NLINKS-1:0] frameSyncPrev_ff;
  logic [NLINKS-1:0] cellSyncPrev_ff;
  logic [NLINKS-1:0] frameLost;
  logic [NLINKS-1:0] cellLost;
  logic              pready_ff;
  logic [31:0]       prdata_ff;
  logic [31:0]       nxt_prdata;
  logic              pslverr_ff;
  logic              nxt_err;
  logic              irq_ff;
  logic              setupPh;
  logic              wrDone;
  logic              wrLoad;
  logic              wrStat;
  logic              wrMask;
  logic              pendAny;

  // outputs straight from flops
  assign pready  = pready_ff;
  assign prdata  = prdata_ff;
  assign pslverr = pslverr_ff;
  assign irq     = irq_ff;

  // bus phase decode
  assign setupPh = psel & ~penable;
  assign wrDone  = psel & penable & pready_ff & pwrite;       // [R15]
  assign wrLoad  = wrDone & pstrb[0] & regHit(paddr, `IDX_LOAD_SEL);
  assign wrStat  = wrDone & pstrb[0] & regHit(paddr, `IDX_EV_STAT);
  assign wrMask  = wrDone & pstrb[0] & regHit(paddr, `IDX_EV_MASK);
  assign selNew  = pwdata[`SEL_W-1:0];

  // one wait-free answer: ready in the first access cycle
  always_ff @(posedge clk)
  begin
    if (rst)
      pready_ff <= 1'b0;
    else
      pready_ff <= setupPh & ~pready_ff;
  end

  // read decode, taken in the setup cycle, no side effects
  always_comb
  begin
    nxt_prdata = 32'h0000_0000;
    nxt_err    = 1'b0;
    if (regHit(paddr, `IDX_LINK_ID))
      nxt_prdata = 32'(linkIdSnap_ff);                 // [R3]
    else if (regHit(paddr, `IDX_STATE))
      nxt_prdata = 32'(stateSnap_ff);                  // [R3]
    else if (regHit(paddr, `IDX_FRAME_SYNC))
      nxt_prdata = 32'(frameSynced);                   // [R12] [R13]
    else if (regHit(paddr, `IDX_CELL_SYNC))
      nxt_prdata = 32'(cellSynced);                    // [R14]
    else if (regHit(paddr, `IDX_LOAD_SEL))
      nxt_prdata = 32'(linkSel_ff);
    else if (regHit(paddr, `IDX_EV_STAT))
      nxt_prdata = 32'(evStat_ff);
    else if (regHit(paddr, `IDX_EV_MASK))
      nxt_prdata = 32'(evMask_ff);
    else
      nxt_err = 1'b1;
  end

  // read data and error held through the access phase
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      prdata_ff  <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
    end
    else if (setupPh)
    begin
      prdata_ff  <= pwrite ? 32'h0000_0000 : nxt_prdata;
      pslverr_ff <= nxt_err;
    end
  end

  // selected link record, out-of-range select gives zeros
  always_comb
  begin
    cap = '0;
    if (32'(selNew) < NLINKS)
      cap = linkStat[selNew];                          // [R2]
  end

  // snapshot fields from the selected link
  always_comb
  begin
    nxt_linkIdSnap           = '0;                     // [R3]
    nxt_linkIdSnap.frameLoss = cap.frameLoss;          // [R4]
    nxt_linkIdSnap.delinLoss = cap.delinLoss;          // [R5]
    nxt_linkIdSnap.refLink   = cap.refLink;            // [R6]
    nxt_linkIdSnap.linkId    = cap.linkId;             // [R7]
    nxt_stateSnap            = '0;                     // [R3]
    nxt_stateSnap.frameLen   = cap.frameLen;           // [R9]
    nxt_stateSnap.frameState = cap.frameState;         // [R10]
    // the unused code is reported as hunt
    if (cap.cellState == `CD_UNUSED)
      nxt_stateSnap.cellState = `CD_HUNT;              // [R11]
    else
      nxt_stateSnap.cellState = cap.cellState;         // [R11]
  end

  // select register and snapshots, loaded by the load write
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      linkSel_ff    <= '0;
      linkIdSnap_ff <= `LINK_ID_RST;                   // [R8]
      stateSnap_ff  <= `STATE_RST;                     // [R8]
    end
    else if (wrLoad)
    begin
      linkSel_ff    <= selNew;                         // [R2]
      linkIdSnap_ff <= nxt_linkIdSnap;                 // [R1]
      stateSnap_ff  <= nxt_stateSnap;                  // [R1]
    end
  end

  // per-link loss of sync detection
  genvar g;
  generate
    for (g = 0; g < NLINKS; g++)
    begin : g_lost
      assign frameLost[g] = frameSyncPrev_ff[g] & ~frameSynced[g];
      assign cellLost[g]  = cellSyncPrev_ff[g] & ~cellSynced[g];
    end
  endgenerate

  // previous sync levels for edge detection
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      frameSyncPrev_ff <= '0;
      cellSyncPrev_ff  <= '0;
    end
    else
    begin
      frameSyncPrev_ff <= frameSynced;
      cellSyncPrev_ff  <= cellSynced;
    end
  end

  // sticky events, write one to clear, set wins
  always_comb
  begin
    evSet                 = '0;
    evSet[`EV_LOAD]       = wrLoad;
    evSet[`EV_FRAME_LOST] = |frameLost;
    evSet[`EV_CELL_LOST]  = |cellLost;
    evClr                 = wrStat ? pwdata[`EV_W-1:0] : '0;
    nxt_evStat            = (evStat_ff & ~evClr) | evSet;
  end

  // event status register
  always_ff @(posedge clk)
  begin
    if (rst)
      evStat_ff <= '0;
    else
      evStat_ff <= nxt_evStat;
  end

  // event mask register
  always_ff @(posedge clk)
  begin
    if (rst)
      evMask_ff <= '0;
    else if (wrMask)
      evMask_ff <= pwdata[`EV_W-1:0];
  end

  assign pendAny = |(evStat_ff & evMask_ff);

  // level interrupt, one cycle behind the status
  always_ff @(posedge clk)
  begin
    if (rst)
      irq_ff <= 1'b0;
    else
      irq_ff <= pendAny;
  end

  // snapshots hold unless a load write completes
  snap_hold_a: assert property (                       // [R1]
    @(posedge clk) disable iff (rst)
    !wrLoad |=> $stable(linkIdSnap_ff) && $stable(stateSnap_ff))
    else $error("snapshot changed without a load write");

  // load captures the selected link
  snap_load_a: assert property (                       // [R2]
    @(posedge clk) disable iff (rst)
    wrLoad |=> linkSel_ff == $past(selNew)
      && linkIdSnap_ff.linkId == $past(cap.linkId)
      && stateSnap_ff.frameLen == $past(cap.frameLen))
    else $error("snapshot not taken from the selected link");

  // identity flag bits follow the selected link
  id_flags_a: assert property (                        // [R4] [R5] [R6]
    @(posedge clk) disable iff (rst)
    wrLoad |=> linkIdSnap_ff[7:5] == {$past(cap.frameLoss),
      $past(cap.delinLoss), $past(cap.refLink)})
    else $error("identity flags wrong after load");

  // unused upper bits stay zero
  upper_zero_a: assert property (                      // [R3]
    @(posedge clk) disable iff (rst)
    pready && !pslverr && regHit(paddr, `IDX_LINK_ID)
      |-> prdata[31:8] == 24'h00_0000)
    else $error("identity upper bits not zero");

  // reset values seen right after release
  reset_val_a: assert property (                       // [R8]
    @(posedge clk)
    $past(rst) |-> linkIdSnap_ff == `LINK_ID_RST
      && stateSnap_ff == `STATE_RST && !irq && !pready)
    else $error("reset value wrong");

  // frame state code carried unchanged
  frame_code_a: assert property (                      // [R10]
    @(posedge clk) disable iff (rst)
    wrLoad |=> stateSnap_ff[3:2] == $past(cap.frameState))
    else $error("frame state code wrong");

  // delineation code never reports the unused value
  cd_code_a: assert property (                         // [R11]
    @(posedge clk) disable iff (rst)
    stateSnap_ff.cellState != `CD_UNUSED)
    else $error("unused delineation code reported");

  // frame sync read shows the live level
  frame_live_a: assert property (                      // [R12] [R13]
    @(posedge clk) disable iff (rst)
    setupPh && !pwrite && regHit(paddr, `IDX_FRAME_SYNC)
      |=> pready && prdata == 32'($past(frameSynced)))
    else $error("frame sync read not live");

  // cell sync read shows the live level
  cell_live_a: assert property (                       // [R14]
    @(posedge clk) disable iff (rst)
    setupPh && !pwrite && regHit(paddr, `IDX_CELL_SYNC)
      |=> pready && prdata == 32'($past(cellSynced)))
    else $error("cell sync read not live");

  // writes to status locations change nothing
  ro_write_a: assert property (                        // [R15]
    @(posedge clk) disable iff (rst)
    wrDone && (regHit(paddr, `IDX_LINK_ID) || regHit(paddr, `IDX_STATE)
      || regHit(paddr, `IDX_FRAME_SYNC) || regHit(paddr, `IDX_CELL_SYNC))
      |=> $stable(linkIdSnap_ff) && $stable(stateSnap_ff)
      && $stable(linkSel_ff) && $stable(evMask_ff))
    else $error("read-only write had an effect");

  // ready one cycle after setup, then low
  apb_ready_a: assert property (
    @(posedge clk) disable iff (rst)
    setupPh |=> pready ##1 !pready)
    else $error("ready timing wrong");

  // interrupt follows pending events by one cycle
  irq_level_a: assert property (
    @(posedge clk) disable iff (rst)
    ##1 irq == $past(pendAny))
    else $error("interrupt does not follow pending events");

  // unused state bits read zero
  state_zero_a: assert property (                      // [R3]
    @(posedge clk) disable iff (rst)
    pready && !pslverr && regHit(paddr, `IDX_STATE)
      |-> prdata[31:6] == 26'h0)
    else $error("state upper bits not zero");

  // select register changes only by a load write
  sel_hold_a: assert property (                        // [R2]
    @(posedge clk) disable iff (rst)
    !wrLoad |=> $stable(linkSel_ff))
    else $error("link select changed without a load write");

  // completed load raises its event bit
  load_event_a: assert property (                      // [R1]
    @(posedge clk) disable iff (rst)
    wrLoad |=> evStat_ff[`EV_LOAD])
    else $error("load event not set");

  // frame sync loss on any link raises its event bit
  frame_event_a: assert property (                     // [R12]
    @(posedge clk) disable iff (rst)
    (|frameLost) |=> evStat_ff[`EV_FRAME_LOST])
    else $error("frame sync loss event not set");

  // delineation loss on any link raises its event bit
  cell_event_a: assert property (                      // [R14]
    @(posedge clk) disable iff (rst)
    (|cellLost) |=> evStat_ff[`EV_CELL_LOST])
    else $error("delineation loss event not set");

  // writing one clears the load event
  event_clear_a: assert property (
    @(posedge clk) disable iff (rst)
    wrStat && pwdata[`EV_LOAD] |=> !evStat_ff[`EV_LOAD])
    else $error("load event not cleared by write one");

  // mask changes only by a mask write
  mask_hold_a: assert property (
    @(posedge clk) disable iff (rst)
    !wrMask |=> $stable(evMask_ff))
    else $error("mask changed without a mask write");

  // nothing unmasked, no interrupt
  irq_masked_a: assert property (
    @(posedge clk) disable iff (rst)
    evMask_ff == '0 |=> !irq)
    else $error("interrupt raised with all events masked");

endmodule

`default_nettype wire

// File: tb/link_machines_model.sv
`default_nettype none

// stand-in for the receive frame and delineation machines of 16 links
module link_machines_model (
  input  wire logic                                clk,
  input  wire logic                                en,
  input  wire logic [3:0]                          scene,
  output var rx_link_status_pkg::link_status_t [15:0] linkStat,
  output logic [15:0]                              frameSynced,
  output logic [15:0]                              cellSynced
);
  timeunit 1ns;
  timeprecision 1ps;

  // per-link pattern from the scene; zeros while idle
  always_ff @(posedge clk)
  begin
    for (int i = 0; i < 16; i++)
    begin
      linkStat[i] <= rx_link_status_pkg::link_status_t'(
        en ? 14'(i * 14'h0a53 + scene * 14'h1c6d) : 14'h0000);
    end
    frameSynced <= en ? (16'hc3a5 ^ {4{scene}}) : 16'h0000;
    cellSynced  <= en ? (16'h5a3c + 16'(scene)) : 16'h0000;
  end
endmodule

`default_nettype wire

// File: tb/testbench.sv
`include "rx_link_status_map.svh"
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  logic                                  clk = 1'b0;
  logic                                  rst = 1'b1;
  logic                                  psel = 1'b0;
  logic                                  penable = 1'b0;
  logic                                  pwrite = 1'b0;
  logic [11:0]                           paddr = 12'h000;
  logic [31:0]                           pwdata = 32'h0;
  logic [3:0]                            pstrb = 4'h0;
  logic                                  en = 1'b0;
  logic [3:0]                            scene = 4'h0;
  rx_link_status_pkg::link_status_t [15:0] linkStat;
  logic [15:0]                           frameSynced;
  logic [15:0]                           cellSynced;
  logic                                  pready;
  logic [31:0]                           prdata;
  logic                                  pslverr;
  logic                                  irq;
  logic [31:0]                           r;
  logic                                  e;
  int                                    fails = 0;
  int                                    cmp_count = 0;

  always #20 clk = ~clk;

  rx_link_status_readback #(.NLINKS(16), .PADDR_W(12)) uut (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .linkStat(linkStat), .frameSynced(frameSynced),
    .cellSynced(cellSynced), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .irq(irq));

  link_machines_model machines (
    .clk(clk), .en(en), .scene(scene), .linkStat(linkStat),
    .frameSynced(frameSynced), .cellSynced(cellSynced));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // one apb transfer, held until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [7:0] idx,
                     input logic [31:0] d, input logic [3:0] s);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {2'h0, idx, 2'h0};
    pwdata <= d;
    pstrb <= s;
    @(posedge clk);
    penable <= 1'b1;
    // no timeout here: only the watchdog ends a wait that never sees ready
    do
    begin
      @(posedge clk);
    end
    while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdc(input logic [7:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0, 4'h0);
    chk(r, exp);
    chk({31'h0, e}, 32'h0);
  endtask

  // expected fields worked out from the model's pattern
  function automatic logic [13:0] lv(input int i, input logic [3:0] s);
    return 14'(i * 14'h0a53 + s * 14'h1c6d);
  endfunction

  function automatic logic [31:0] expSt(input logic [13:0] v);
    return {26'h0, v[5:2], (v[1:0] == 2'h3) ? 2'h0 : v[1:0]};
  endfunction

  // identity word: flags and link id from the top eight bits
  function automatic logic [31:0] expId(input logic [13:0] v);
    return {24'h0, v[13:6]};
  endfunction

  task automatic end_sim();
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // watchdog well beyond the expected run
  initial
  begin
    #(40 * 20000);
    fails++;
    end_sim();
  end

  initial
  begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rdc(`IDX_LINK_ID, 32'h20);
    rdc(`IDX_STATE, 32'h0);
    rdc(`IDX_FRAME_SYNC, 32'h0);
    rdc(`IDX_CELL_SYNC, 32'h0);
    chk({31'h0, irq}, 32'h0);
    $display("test reset values done");
    // no load yet, masked-lane load, writes to status
    en <= 1'b1;
    scene <= 4'h3;
    rdc(`IDX_LINK_ID, 32'h20);
    apb(1'b1, `IDX_LOAD_SEL, 32'h5, 4'he);
    rdc(`IDX_LINK_ID, 32'h20);
    apb(1'b1, `IDX_LINK_ID, 32'hffff, 4'hf);
    apb(1'b1, `IDX_STATE, 32'hffff, 4'hf);
    rdc(`IDX_LINK_ID, 32'h20);
    rdc(`IDX_STATE, 32'h0);
    $display("test hold and ignore done");
    // load every link, then change inputs and reread
    for (int k = 0; k < 16; k++)
    begin
      scene <= 4'h5;
      apb(1'b1, `IDX_LOAD_SEL, 32'(k), 4'h1);
      scene <= 4'h9;
      rdc(`IDX_LINK_ID, expId(lv(k, 4'h5)));
      rdc(`IDX_STATE, expSt(lv(k, 4'h5)));
      rdc(`IDX_STATE, expSt(lv(k, 4'h5)));
    end
    $display("test snapshot loads done");
    // live sync registers follow the machines
    for (int s = 0; s < 4; s++)
    begin
      scene <= 4'(s * 5);
      rdc(`IDX_FRAME_SYNC, {16'h0, 16'hc3a5 ^ {4{4'(s * 5)}}});
      rdc(`IDX_CELL_SYNC, {16'h0, 16'h5a3c + 16'(s * 5)});
    end
    $display("test live sync done");
    // unmapped access, events and interrupt
    apb(1'b0, 8'h10, 32'h0, 4'h0);
    chk({31'h0, e}, 32'h1);
    apb(1'b1, `IDX_EV_STAT, 32'h7, 4'hf);
    rdc(`IDX_EV_STAT, 32'h0);
    apb(1'b1, `IDX_EV_MASK, 32'h1, 4'hf);
    rdc(`IDX_EV_MASK, 32'h1);
    apb(1'b1, `IDX_LOAD_SEL, 32'h2, 4'hf);
    rdc(`IDX_EV_STAT, 32'h1);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, `IDX_EV_STAT, 32'h1, 4'hf);
    rdc(`IDX_EV_STAT, 32'h0);
    chk({31'h0, irq}, 32'h0);
    scene <= 4'h1;
    repeat (2) @(posedge clk);            // let the loss events land
    rdc(`IDX_EV_STAT, 32'h6);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, `IDX_EV_MASK, 32'h6, 4'hf);
    rdc(`IDX_EV_MASK, 32'h6);
    chk({31'h0, irq}, 32'h1);
    $display("test events done");
    // a second reset mid-run restores the reset values
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rdc(`IDX_LINK_ID, 32'h20);
    rdc(`IDX_STATE, 32'h0);
    rdc(`IDX_EV_MASK, 32'h0);
    chk({31'h0, irq}, 32'h0);
    $display("test mid-run reset done");
    end_sim();
  end
endmodule

`default_nettype wire
